// ### include/eeprom_spi_pkg.sv
// Purpose: constants and types for the serial eeprom command front end
// Assumes: ref_clk far faster than the serial clock
// Notes:   opcode bit 3 is masked off before decode
package eeprom_spi_pkg;
    localparam logic [7:0] OP_MASK     = 8'hf7;
    localparam logic [7:0] OP_SET_WL   = 8'h06;
    localparam logic [7:0] OP_CLR_WL   = 8'h04;
    localparam logic [7:0] OP_STAT_RD  = 8'h05;
    localparam logic [7:0] OP_STAT_WR  = 8'h01;
    localparam logic [7:0] OP_ARR_RD   = 8'h03;
    localparam logic [7:0] OP_ARR_WR   = 8'h02;
    localparam logic [7:0] OP_ID_RD    = 8'h83;
    localparam logic [7:0] OP_ID_WR    = 8'h82;
    localparam int         ID_SEL_BIT  = 10;
    localparam int         BUSY_BIT    = 0;
    localparam int         WEL_BIT     = 1;
    localparam int         LOCK_EN_BIT = 7;
    localparam int         LOCK_DATA_BIT = 1;
    localparam logic [1:0] BP_NONE     = 2'h0;
    localparam logic [1:0] BP_QUARTER  = 2'h1;
    localparam logic [1:0] BP_HALF     = 2'h2;
    localparam logic [1:0] BP_ALL      = 2'h3;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [7:0] BUSY_STATUS = 8'hff;

    typedef enum logic [1:0] {wk_status, wk_array, wk_id, wk_lock} write_kind_t;
    typedef enum {st_idle, st_opcode, st_addr, st_din, st_dout, st_ignore} state_t;
    typedef enum {cmd_none, cmd_set_wl, cmd_clr_wl, cmd_stat_rd, cmd_stat_wr,
                  cmd_arr_rd, cmd_arr_wr, cmd_id_rd, cmd_id_wr, cmd_lock} cmd_t;
    typedef struct packed {
        logic        id_page;
        logic [14:0] addr;
        logic [7:0]  data;
    } byte_req_t;
endpackage : eeprom_spi_pkg

// ### design/spi_eeprom_command_interface.sv
// Purpose: spi slave command decoder and status register of the eeprom
// Assumes: pins sampled by ref_clk; write engine reports busy
// Notes:   array/id storage and write timing live outside this block
`timescale 1ns/10ps
module spi_eeprom_command_interface
    import eeprom_spi_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      arst_n,
    input  wire logic      chip_select_n,
    input  wire logic      serial_clock,
    input  wire logic      serial_in,
    input  wire logic      write_protect_n,
    input  wire logic      hold_n,
    output logic           serial_out,
    output logic           serial_out_en,
    output logic [15:0]    read_addr,
    output logic           read_id_page,
    input  wire logic [7:0] array_rd_data,
    input  wire logic      id_locked,
    output byte_req_t      byte_req,
    output logic           byte_req_valid,
    output logic           write_start,
    output write_kind_t    write_kind,
    input  wire logic      write_busy,
    output logic [7:0]     status_value
);
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    state_t      state;
    cmd_t        cmd;
    logic [2:0]  in_cnt;
    logic [2:0]  out_cnt;
    logic [7:0]  in_shift;
    logic [7:0]  out_shift;
    logic        addr_hi_done;
    logic [15:0] addr;
    logic        got_byte;
    logic        wrote_any;
    logic [7:0]  pend;
    logic        wel;
    logic [1:0]  bp;
    logic        lock_en;

    // first stage read only by the second; third stage feeds edge detect
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
        end else begin
            s1 <= {hold_n, write_protect_n, serial_in, serial_clock, chip_select_n};
            s2 <= s1;
            s3 <= s2;
        end
    end

    wire cs_n_s   = s2[0];
    wire sck_s    = s2[1];
    wire si_s     = s2[2];
    wire wp_n_s   = s2[3];
    wire hold_s   = s2[4];
    wire cs_fall  = !s2[0] && s3[0];
    wire cs_rise  = s2[0] && !s3[0];
    // hold gates the clock edges and the output enable, not select, so select still ends a frame
    wire live     = !cs_n_s && hold_s;
    wire sck_rise = live && sck_s && !s3[1];
    wire sck_fall = live && !sck_s && s3[1];
    wire busy     = write_busy;
    wire hw_prot  = !wp_n_s && lock_en;
    wire [7:0] next_in   = {in_shift[6:0], si_s};
    wire       byte_done = sck_rise && (in_cnt == LAST_BIT);
    wire [15:0] full_addr = {addr[7:0], next_in};
    wire [7:0] op        = next_in & OP_MASK;

    // status image; bits 4..6 never stored
    assign status_value = busy ? BUSY_STATUS
                               : {lock_en, 3'h0, bp, wel, busy};

    cmd_t next_cmd;
    always_comb begin
        next_cmd = cmd_none;
        if (busy && op != OP_STAT_RD)
            next_cmd = cmd_none;
        else if (op == OP_SET_WL)
            next_cmd = cmd_set_wl;
        else if (op == OP_CLR_WL)
            next_cmd = cmd_clr_wl;
        else if (op == OP_STAT_RD)
            next_cmd = cmd_stat_rd;
        else if (op == OP_STAT_WR)
            next_cmd = cmd_stat_wr;
        else if (op == OP_ARR_RD)
            next_cmd = cmd_arr_rd;
        else if (op == OP_ARR_WR)
            next_cmd = cmd_arr_wr;
        else if (op == OP_ID_RD)
            next_cmd = cmd_id_rd;
        else if (op == OP_ID_WR)
            next_cmd = cmd_id_wr;
    end

    state_t next_state_op;
    always_comb begin
        case (next_cmd)
            cmd_none:    next_state_op = st_ignore;
            cmd_set_wl:  next_state_op = st_ignore;
            cmd_clr_wl:  next_state_op = st_ignore;
            cmd_stat_rd: next_state_op = st_dout;
            cmd_stat_wr: next_state_op = st_din;
            default:     next_state_op = st_addr;
        endcase
    end

    // after the address: id select bit picks id page vs lock operations
    wire id_sel = full_addr[ID_SEL_BIT];
    state_t next_state_addr;
    cmd_t   cmd_after_addr;
    always_comb begin
        next_state_addr = st_din;
        cmd_after_addr  = cmd;
        case (cmd)
            cmd_arr_rd: next_state_addr = st_dout;
            cmd_id_rd:  next_state_addr = id_sel ? st_ignore : st_dout;
            cmd_id_wr: begin
                if (id_sel) begin
                    // lock read and lock share the opcode: shift out and capture
                    cmd_after_addr  = cmd_lock;
                    next_state_addr = st_dout;
                end
            end
            default: next_state_addr = st_din;
        endcase
    end

    function automatic logic in_protected(input logic [1:0] b, input logic [14:0] a);
        case (b)
            BP_NONE:    in_protected = 1'b0;
            BP_QUARTER: in_protected = a[14] && a[13];
            BP_HALF:    in_protected = a[14];
            default:    in_protected = 1'b1;
        endcase
    endfunction : in_protected

    wire arr_ok = wel && !in_protected(bp, addr[14:0]);
    wire id_ok  = wel && !id_locked;
    wire wr_ok  = (cmd == cmd_arr_wr) ? arr_ok : id_ok;
    wire [15:0] next_wr_addr = {addr[15:6], addr[5:0] + 6'h01};    // page wrap
    wire [15:0] next_rd_addr = (cmd == cmd_arr_rd) ? {1'b0, addr[14:0] + 15'h0001}
                                                   : next_wr_addr;
    wire [7:0] load_byte = (cmd == cmd_stat_rd) ? status_value
                         : (cmd == cmd_lock) ? {7'h00, id_locked} : array_rd_data;
    wire at_boundary = (in_cnt == 3'h0);

    // completion at select rising, only on a byte boundary
    wire stat_take = cmd == cmd_stat_wr && got_byte && !hw_prot && wel;
    wire lock_take = cmd == cmd_lock && got_byte && wel && bp != BP_ALL
                     && pend[LOCK_DATA_BIT];
    wire data_take = (cmd == cmd_arr_wr || cmd == cmd_id_wr) && wrote_any;
    wire finish    = cs_rise && at_boundary && state != st_idle;
    wire clr_wel   = finish && (cmd == cmd_clr_wl || (cmd == cmd_stat_wr && got_byte)
                     || data_take || lock_take);
    wire set_wel   = finish && cmd == cmd_set_wl;
    wire next_lock = (!wp_n_s && lock_en) ? 1'b1 : pend[LOCK_EN_BIT];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_idle;
            cmd   <= cmd_none;
        end else if (cs_rise) begin
            state <= st_idle;
        end else if (cs_fall && !cs_n_s) begin
            state <= st_opcode;
            cmd   <= cmd_none;
        end else if (byte_done && state == st_opcode) begin
            state <= next_state_op;
            cmd   <= next_cmd;
        end else if (byte_done && state == st_addr && addr_hi_done) begin
            state <= next_state_addr;
            cmd   <= cmd_after_addr;
        end else if (byte_done && state == st_din && cmd == cmd_stat_wr) begin
            state <= st_ignore;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            in_cnt       <= 3'h0;
            in_shift     <= 8'h00;
            addr_hi_done <= 1'b0;
            addr         <= 16'h0000;
            got_byte     <= 1'b0;
            pend         <= 8'h00;
        end else if (cs_fall) begin
            in_cnt       <= 3'h0;
            addr_hi_done <= 1'b0;
            got_byte     <= 1'b0;
        end else if (sck_rise && state != st_idle && state != st_ignore) begin
            in_cnt   <= in_cnt + 3'h1;
            in_shift <= next_in;
            if (byte_done && state == st_addr) begin
                addr         <= full_addr;
                addr_hi_done <= 1'b1;
            end
            if (byte_done && (state == st_din || cmd == cmd_lock)) begin
                pend     <= next_in;
                got_byte <= 1'b1;
            end
            if (byte_done && state == st_din && cmd != cmd_stat_wr)
                addr <= next_wr_addr;
        end else if (sck_fall && state == st_dout && out_cnt == 3'h0 && cmd != cmd_lock) begin
            addr <= next_rd_addr;
        end
    end

    // output shifter; bits change only on falling serial clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt    <= 3'h0;
            out_shift  <= 8'h00;
            serial_out <= 1'b0;
        end else if (cs_fall) begin
            out_cnt <= 3'h0;
        end else if (sck_fall && state == st_dout) begin
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                serial_out <= load_byte[7];
                out_shift  <= {load_byte[6:0], 1'b0};
            end else begin
                serial_out <= out_shift[7];
                out_shift  <= {out_shift[6:0], 1'b0};
            end
        end
    end

    assign serial_out_en = state == st_dout && live;
    assign read_addr     = addr;
    assign read_id_page  = cmd == cmd_id_rd;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_req       <= '0;
            byte_req_valid <= 1'b0;
            wrote_any      <= 1'b0;
        end else begin
            byte_req_valid <= 1'b0;
            if (cs_fall)
                wrote_any <= 1'b0;
            else if (byte_done && state == st_din && cmd != cmd_stat_wr && wr_ok) begin
                byte_req       <= '{id_page: cmd == cmd_id_wr, addr: addr[14:0],
                                    data: next_in};
                byte_req_valid <= 1'b1;
                wrote_any      <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wel         <= 1'b0;
            bp          <= BP_NONE;
            lock_en     <= 1'b0;
            write_start <= 1'b0;
            write_kind  <= wk_status;
        end else begin
            write_start <= finish && (stat_take || lock_take || data_take);
            if (set_wel)
                wel <= 1'b1;
            else if (clr_wel)
                wel <= 1'b0;
            if (finish && stat_take) begin
                bp         <= pend[3:2];
                lock_en    <= next_lock;
                write_kind <= wk_status;
            end else if (finish && lock_take) begin
                write_kind <= wk_lock;
            end else if (finish && data_take) begin
                write_kind <= (cmd == cmd_arr_wr) ? wk_array : wk_id;
            end
        end
    end

    // checks
    a_out_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state != st_dout |-> !serial_out_en)
        else $error("serial out driven outside data phase");
    a_busy_ones: assert property (@(posedge ref_clk) disable iff (!arst_n)
        write_busy |-> status_value == BUSY_STATUS)
        else $error("status not all ones while busy");
    a_busy_reject: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state == st_opcode && byte_done && busy && op != OP_STAT_RD && !cs_rise
        |=> state == st_ignore)
        else $error("command taken while busy");
    a_undef_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state == st_ignore && !cs_rise && !cs_fall |=> state == st_ignore
        && !byte_req_valid && $stable(addr))
        else $error("ignored frame acted");
    a_wel_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        byte_req_valid |-> $past(wel, 1))
        else $error("byte written with latch clear");
    a_block_prot: assert property (@(posedge ref_clk) disable iff (!arst_n)
        byte_req_valid && !byte_req.id_page |-> !in_protected(bp, byte_req.addr))
        else $error("protected block written");
    a_hw_freeze: assert property (@(posedge ref_clk) disable iff (!arst_n)
        hw_prot |=> bp == $past(bp) && lock_en)
        else $error("protect bits changed under hardware protection");
    a_wel_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        write_start |-> !wel ##1 !wel)
        else $error("latch left set after write");
    a_cs_ends: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cs_rise |=> state == st_idle && !serial_out_en)
        else $error("frame not ended by select");
    a_hold_freeze: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !hold_s && !cs_fall |=> $stable(in_cnt) && $stable(out_cnt))
        else $error("transfer moved during hold");
    a_msb_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sck_fall && state == st_dout && out_cnt == 3'h0 |=> serial_out == $past(load_byte[7]))
        else $error("first output bit not msb");

    c_stat_write: cover property (@(posedge ref_clk) disable iff (!arst_n)
        finish && stat_take);
    c_arr_write: cover property (@(posedge ref_clk) disable iff (!arst_n)
        write_start && write_kind == wk_array);
    c_arr_read: cover property (@(posedge ref_clk) disable iff (!arst_n)
        state == st_dout && cmd == cmd_arr_rd && out_cnt == LAST_BIT);
    c_hold_mid: cover property (@(posedge ref_clk) disable iff (!arst_n)
        state == st_addr && !hold_s);
endmodule : spi_eeprom_command_interface

// ### verification/spi_host_model.sv
// Purpose: behavioural spi host that drives the eeprom front end pins
// Assumes: half serial period of four ref_clk cycles, 80 ns per bit
// Notes:   each bit opens with the clock driven low so mode 0 and mode 3 share one loop
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic ref_clk,
    input  wire logic serial_out,
    input  wire logic serial_out_en,
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      serial_in,
    output logic      hold_n
);
    logic cpol;
    initial begin
        cpol          = 1'b0;
        chip_select_n = 1'b1;
        serial_clock  = 1'b0;
        serial_in     = 1'b0;
        hold_n        = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_clk
    // select only from idle clock level, one instruction per select
    task automatic sel(input logic mode3);
        @(posedge ref_clk);
        cpol = mode3;
        serial_clock <= mode3;
        wait_clk(4);
        chip_select_n <= 1'b0;
        wait_clk(4);
    endtask : sel
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic en);
        en = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            serial_clock <= 1'b0;
            serial_in    <= tx[i];
            wait_clk(4);
            serial_clock <= 1'b1;
            #1;
            rx[i] = serial_out;
            en = en | serial_out_en;
            wait_clk(4);
        end
    endtask : xfer
    // select rises while the clock is still high, before any later rise
    task automatic desel();
        chip_select_n <= 1'b1;
        serial_in     <= ~serial_in;
        wait_clk(4);
        serial_clock <= cpol;
        wait_clk(4);
    endtask : desel
    // hold moves only while the clock is low; garbage clocks meanwhile
    task automatic pause(input int n);
        serial_clock <= 1'b0;
        wait_clk(4);
        hold_n <= 1'b0;
        wait_clk(4);
        repeat (n) begin
            serial_clock <= 1'b1;
            serial_in    <= ~serial_in;
            wait_clk(4);
            serial_clock <= 1'b0;
            wait_clk(4);
        end
        hold_n <= 1'b1;
        wait_clk(4);
    endtask : pause
endmodule : spi_host_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the serial eeprom command front end
// Assumes: write engine raises busy the cycle after write_start
// Notes:   memory model returns address low byte xor 3c, id page xor 5a
`timescale 1ns/10ps
module tb_top;
    import eeprom_spi_pkg::*;
    logic        ref_clk, arst_n, write_protect_n, id_locked, write_busy;
    logic        chip_select_n, serial_clock, serial_in, hold_n, serial_out, serial_out_en;
    logic [15:0] read_addr;
    logic        read_id_page, byte_req_valid, write_start, e;
    byte_req_t   byte_req, last_req;
    write_kind_t write_kind, last_kind;
    logic [7:0]  status_value, rx, r;
    // distinct mask on the id page so a wrong page select shows up
    wire  [7:0]  array_rd_data = read_addr[7:0] ^ (read_id_page ? 8'h5a : 8'h3c);
    // released output line shows the inverse, so off-phase sampling fails
    wire         so_line = serial_out_en ? serial_out : ~serial_out;
    int          mismatches, n_checks, n_req, n_start, busy_cnt, n0;

    spi_eeprom_command_interface i_spi_eeprom_command_interface (.ref_clk(ref_clk),
        .arst_n(arst_n), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_in(serial_in), .write_protect_n(write_protect_n), .hold_n(hold_n),
        .serial_out(serial_out), .serial_out_en(serial_out_en), .read_addr(read_addr),
        .read_id_page(read_id_page), .array_rd_data(array_rd_data), .id_locked(id_locked),
        .byte_req(byte_req), .byte_req_valid(byte_req_valid), .write_start(write_start),
        .write_kind(write_kind), .write_busy(write_busy), .status_value(status_value));
    spi_host_model i_spi_host_model (.ref_clk(ref_clk), .serial_out(so_line),
        .serial_out_en(serial_out_en), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_in(serial_in), .hold_n(hold_n));

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // engine stand-in: busy for 300 cycles, long enough to read status inside it
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_busy <= 1'b0;
            busy_cnt   <= 0;
            n_start    <= 0;
            n_req      <= 0;
        end else if (write_start) begin
            write_busy <= 1'b1;
            busy_cnt   <= 300;
            n_start    <= n_start + 1;
            last_kind  <= write_kind;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            if (busy_cnt == 1) write_busy <= 1'b0;
        end
        if (byte_req_valid) begin
            n_req    <= n_req + 1;
            last_req <= byte_req;
        end
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nd, input logic m3);
        i_spi_host_model.sel(m3);
        i_spi_host_model.xfer(op, r, e);
        if (nd > 0) i_spi_host_model.xfer(d, r, e);
        i_spi_host_model.desel();
        rx = r;
    endtask : cmd
    task automatic arr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
        i_spi_host_model.sel(1'b0);
        i_spi_host_model.xfer(op, r, e);
        i_spi_host_model.xfer(a[15:8], r, e);
        i_spi_host_model.xfer(a[7:0], r, e);
        i_spi_host_model.xfer(d, r, e);
        i_spi_host_model.desel();
    endtask : arr
    task automatic wait_ready();
        for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(posedge ref_clk);
        chk("engine idle", 24'h0, {23'h0, write_busy});
    endtask : wait_ready
    task automatic rd_status(input string what, input logic [7:0] exp);
        cmd(OP_STAT_RD, 8'h00, 1, 1'b0);
        chk(what, {16'h0, exp}, {16'h0, rx});
        chk({what, " image"}, {16'h0, exp}, {16'h0, status_value});
    endtask : rd_status

    task automatic t_latch();
        rd_status("status after reset", 8'h00);
        cmd(OP_SET_WL | 8'h08, 8'h00, 0, 1'b0);
        rd_status("latch set", 8'h02);
        cmd(OP_CLR_WL, 8'h00, 0, 1'b0);
        rd_status("latch cleared", 8'h00);
    endtask : t_latch
    task automatic t_status_write();
        cmd(OP_SET_WL, 8'h00, 0, 1'b1);
        n0 = n_start;
        cmd(OP_STAT_WR, 8'hfc, 1, 1'b1);
        chk("status write launched", 24'h1, 24'(n_start - n0));
        chk("write kind", {22'h0, wk_status}, {22'h0, last_kind});
        rd_status("busy status", BUSY_STATUS);
        wait_ready();
        rd_status("status stored", 8'h8c);
    endtask : t_status_write
    task automatic t_protect();
        write_protect_n <= 1'b0;
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        cmd(OP_STAT_WR, 8'h00, 1, 1'b0);
        wait_ready();
        rd_status("hardware protected", 8'h8c);
        write_protect_n <= 1'b1;
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        cmd(OP_STAT_WR, 8'h04, 1, 1'b0);
        wait_ready();
        rd_status("unprotected write", 8'h04);
        cmd(OP_STAT_WR, 8'h08, 1, 1'b0);
        wait_ready();
        rd_status("write without latch", 8'h04);
    endtask : t_protect
    task automatic t_array_write();
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        n0 = n_req;
        arr(OP_ARR_WR, 16'h6000, 8'h11);
        wait_ready();
        chk("protected quarter", 24'h0, 24'(n_req - n0));
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        i_spi_host_model.sel(1'b0);
        i_spi_host_model.xfer(OP_ARR_WR, r, e);
        i_spi_host_model.xfer(8'h5f, r, e);
        i_spi_host_model.pause(3);
        i_spi_host_model.xfer(8'hff, r, e);
        i_spi_host_model.xfer(8'ha5, r, e);
        i_spi_host_model.desel();
        chk("array byte", {1'b0, 15'h5fff, 8'ha5}, last_req);
        chk("array kind", {22'h0, wk_array}, {22'h0, last_kind});
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        wait_ready();
        rd_status("set while busy", 8'h04);
    endtask : t_array_write
    task automatic t_array_read();
        i_spi_host_model.sel(1'b0);
        i_spi_host_model.xfer(OP_ARR_RD, r, e);
        i_spi_host_model.xfer(8'h00, r, e);
        i_spi_host_model.xfer(8'h12, r, e);
        chk("output off in address", 24'h0, {23'h0, e});
        i_spi_host_model.xfer(8'h00, r, e);
        chk("read byte", {16'h0, 8'h12 ^ 8'h3c}, {16'h0, r});
        chk("output on in data", 24'h1, {23'h0, e});
        chk("array page flag", 24'h0, {23'h0, read_id_page});
        i_spi_host_model.xfer(8'h00, r, e);
        chk("next byte", {16'h0, 8'h13 ^ 8'h3c}, {16'h0, r});
        i_spi_host_model.desel();
        chk("output off after select", 24'h0, {23'h0, serial_out_en});
    endtask : t_array_read
    task automatic t_undefined_and_id();
        i_spi_host_model.sel(1'b0);
        i_spi_host_model.xfer(8'hff, r, e);
        i_spi_host_model.xfer(OP_SET_WL, r, e);
        i_spi_host_model.desel();
        rd_status("undefined opcode", 8'h04);
        id_locked <= 1'b1;
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        n0 = n_req;
        arr(OP_ID_WR, 16'h0005, 8'h77);
        wait_ready();
        chk("locked id page", 24'h0, 24'(n_req - n0));
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        arr(OP_ID_WR, 16'h0400, 8'h02);
        chk("lock status byte", 24'h1, {16'h0, r});
        chk("lock kind", {22'h0, wk_lock}, {22'h0, last_kind});
        wait_ready();
        id_locked <= 1'b0;
        cmd(OP_SET_WL, 8'h00, 0, 1'b0);
        arr(OP_ID_WR, 16'h0005, 8'h77);
        wait_ready();
        chk("id page byte", {1'b1, 15'h0005, 8'h77}, last_req);
        arr(OP_ID_RD, 16'h0005, 8'h00);
        chk("id read byte", {16'h0, 8'h05 ^ 8'h5a}, {16'h0, r});
        chk("id page flag", 24'h1, {23'h0, read_id_page});
    endtask : t_undefined_and_id

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        {mismatches, n_checks} = '0;
        arst_n          = 1'b0;
        write_protect_n = 1'b1;
        id_locked       = 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_latch();
        t_status_write();
        t_protect();
        t_array_write();
        t_array_read();
        t_undefined_and_id();
        finish_test();
    end
    // whole run needs about 6k cycles; cut off at about eight times that
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
endmodule : tb_top
